// File: design/swp_params.svh
// offsets, field positions, reset values and timing constants of the write-guard and loop block
`ifndef SWP_PARAMS_SVH
`define SWP_PARAMS_SVH
`define SWP_OFS_REG_UNLOCK   16'h0020
`define SWP_OFS_REG_GUARD    16'h0021
`define SWP_OFS_CTRL_UNLOCK  16'h0030
`define SWP_OFS_CTRL_GUARD   16'h0031
`define SWP_OFS_CTRL_GUARD_H 16'h0032
`define SWP_OFS_LL_CTRL_0    16'h0100
`define SWP_OFS_LL_CTRL_1    16'h0101
`define SWP_OFS_LL_CTRL_2    16'h0102
`define SWP_OFS_LL_CTRL_3    16'h0103
`define SWP_GUARD_LO_END     16'h0137
`define SWP_GUARD_HI_START   16'h013A
`define SWP_GUARD_HI_END     16'h0F0F
`define SWP_BIT_GUARD        0
`define SWP_BIT_FWD_DROP     0
`define SWP_BIT_TEMP_USE     1
`define SWP_BIT_SRC_LOCAL    1
`define SWP_RST_GUARD        1'b0
`define SWP_RST_LL_CTRL_0    2'b00
`define SWP_RST_LOOP_BYTE    8'h00
`define SWP_TEMP_TIME_MS     1000
`define SWP_CLK_KHZ          125000
`endif

// File: design/swp_pkg.sv
// types of the write-guard and loop block
package swp_pkg;
  typedef logic [15:0] swp_addr_t;
  typedef logic [7:0]  swp_byte_t;
  // per-port loop configuration codes, in field order 00..11
  typedef enum logic [1:0] {LOOP_AUTO, LOOP_AUTO_CLOSE, LOOP_OPEN, LOOP_CLOSED} swp_loop_e;
  // temporary settings timer
  typedef enum logic {TEMP_IDLE, TEMP_RUN} swp_temp_e;
endpackage

// File: design/swp_loop_if.sv
// control and state of one port loop between the register bank and the port logic
`timescale 1ns/10ps
interface swp_loop_if;
  import swp_pkg::*;
  swp_loop_e mode;
  logic      linkUp;
  logic      busy;
  logic      validRx;
  logic      rewrite;
  logic      closed;
  modport ctl  (output mode, linkUp, busy, validRx, rewrite, input closed);
  modport port (input mode, linkUp, busy, validRx, rewrite, output closed);
endinterface

// File: design/swp_loop_port.sv
// loop open/closed state of one port
`timescale 1ns/10ps
module swp_loop_port (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // port loop carrier
  swp_loop_if.port lp
);
  import swp_pkg::*;

  logic autoCloseHeld;
  logic wantClosed;

  ////////////////////////////////////////////////////////////////////////////
  // auto-close latch: link loss wins over reopen
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      autoCloseHeld <= 1'b0;
    end else if (lp.mode != LOOP_AUTO_CLOSE) begin
      autoCloseHeld <= 1'b0;
    end else if (!lp.linkUp) begin
      autoCloseHeld <= 1'b1;
    end else if (lp.rewrite || lp.validRx) begin
      autoCloseHeld <= 1'b0;
    end
  end

  // target loop state per mode
  always_comb begin
    case (lp.mode)
      LOOP_AUTO:       wantClosed = !lp.linkUp;
      LOOP_AUTO_CLOSE: wantClosed = autoCloseHeld;
      LOOP_OPEN:       wantClosed = 1'b0;
      LOOP_CLOSED:     wantClosed = 1'b1;
      default:         wantClosed = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lp.closed <= 1'b0;
    end else if (!lp.busy) begin
      lp.closed <= wantClosed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_LOOP_HOLD: assert property (lp.busy |=> $stable(lp.closed))
    else $error("loop state changed during a frame");
  AST_LOOP_FORCED: assert property (!lp.busy && lp.mode == LOOP_CLOSED |=> lp.closed)
    else $error("forced-closed port not closed");
  AST_LOOP_OPEN: assert property (!lp.busy && lp.mode == LOOP_OPEN |=> !lp.closed)
    else $error("forced-open port not open");
  AST_LOOP_AUTO: assert property (!lp.busy && lp.mode == LOOP_AUTO |=> lp.closed == !$past(lp.linkUp))
    else $error("auto loop does not follow link");
  AST_LOOP_ACLOSE: assert property (lp.mode == LOOP_AUTO_CLOSE && !lp.linkUp ##1 lp.mode == LOOP_AUTO_CLOSE
                                    && !lp.busy |=> lp.closed)
    else $error("auto-close port not closed after link loss");
endmodule

// File: design/swp_write_guard.sv
// write protection, frame forwarding and loop control register bank
//
// Contract
// - register unlock needed earlier in same frame
// - register protection persists until guard rewritten
// - register guard covers two address ranges
// - controller guard blocks all but unlock
// - controller unlock write opens later writes
// - controller protection persists until guard rewritten
// - foreign frames forwarded or destroyed per bit
// - forwarded frames get locally administered source
// - temporary loop settings revert after one second
// - four two-bit loop fields: auto, auto close, open or closed
// - auto mode follows link state
// - auto close reopens by rewrite or frame
// - open and closed codes ignore link
// - loop changes wait for frame end
`timescale 1ns/10ps
`include "swp_params.svh"
module swp_write_guard #(
  parameter int TEMP_CYCLES = `SWP_TEMP_TIME_MS * `SWP_CLK_KHZ
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // network frame delimiters and classification
  input  wire logic              frameStart,
  input  wire logic              frameEnd,
  input  wire logic              frameIsFieldbus,
  input  wire swp_pkg::swp_byte_t frameSrcAddrByteIn,
  // network register access, one byte per strobe
  input  wire logic              netWrStrobe,
  input  wire swp_pkg::swp_addr_t netWrAddr,
  input  wire swp_pkg::swp_byte_t netWrData,
  input  wire swp_pkg::swp_addr_t netRdAddr,
  output      swp_pkg::swp_byte_t netRdData,
  // local process interface, read only
  input  wire swp_pkg::swp_addr_t lpiRdAddr,
  output      swp_pkg::swp_byte_t lpiRdData,
  // accepted writes to the rest of the controller
  output      logic              extWrEn,
  output      swp_pkg::swp_addr_t extWrAddr,
  output      swp_pkg::swp_byte_t extWrData,
  output      logic              wrRefused,
  // frame handling decision
  output      logic              frameProcess,
  output      logic              frameForward,
  output      logic              frameDrop,
  output      swp_pkg::swp_byte_t frameSrcAddrByteOut,
  // ports
  input  wire logic [3:0]        linkUp,
  input  wire logic [3:0]        portBusy,
  input  wire logic [3:0]        portValidRx,
  output      logic [3:0]        loopClosed
);
  import swp_pkg::*;

  logic       regGuard;
  logic       ctrlGuard;
  logic       regUnlocked;
  logic       ctrlUnlocked;
  logic [1:0] llCtrl0;
  swp_byte_t  loopByte;
  swp_byte_t  savedLoopByte;
  swp_temp_e  tempState;
  logic [31:0] tempCnt;
  logic [3:0] rewritePulse;
  logic [3:0] closedNow;

  ////////////////////////////////////////////////////////////////////////////
  // address decoding
  function automatic logic inRegGuardRange(input swp_addr_t a);
    return (a <= `SWP_GUARD_LO_END) || (a >= `SWP_GUARD_HI_START && a <= `SWP_GUARD_HI_END);
  endfunction

  function automatic swp_byte_t readByte(input swp_addr_t a, input logic rg, input logic cg,
                                         input logic [1:0] c0, input swp_byte_t lb);
    case (a)
      `SWP_OFS_REG_GUARD:  return {7'h00, rg};
      `SWP_OFS_CTRL_GUARD: return {7'h00, cg};
      `SWP_OFS_LL_CTRL_0:  return {6'h00, c0};
      `SWP_OFS_LL_CTRL_1:  return lb;
      default:             return 8'h00;
    endcase
  endfunction

  wire isCtrlUnlockAddr = (netWrAddr == `SWP_OFS_CTRL_UNLOCK);
  wire isRegUnlockAddr  = (netWrAddr == `SWP_OFS_REG_UNLOCK);
  // a start pulse opens a new frame, so old unlocks no longer count
  wire ctrlOpen = ctrlUnlocked && !frameStart;
  wire regOpen  = regUnlocked && !frameStart;
  wire ctrlBlocks = ctrlGuard && !ctrlOpen && !isCtrlUnlockAddr;
  // two ranges, both unlock registers exempt
  wire regBlocks = regGuard && !regOpen && !isRegUnlockAddr && !isCtrlUnlockAddr && inRegGuardRange(netWrAddr);
  wire wrOk = netWrStrobe && !ctrlBlocks && !regBlocks;
  wire wrReg = wrOk && (netWrAddr == `SWP_OFS_REG_GUARD);
  wire wrCtrl = wrOk && (netWrAddr == `SWP_OFS_CTRL_GUARD);
  wire wrLl0 = wrOk && (netWrAddr == `SWP_OFS_LL_CTRL_0);
  wire wrLl1 = wrOk && (netWrAddr == `SWP_OFS_LL_CTRL_1);
  wire isLocal = (netWrAddr == `SWP_OFS_REG_GUARD) || (netWrAddr == `SWP_OFS_CTRL_GUARD)
              || (netWrAddr == `SWP_OFS_LL_CTRL_0) || (netWrAddr == `SWP_OFS_LL_CTRL_1);
  wire tempDone = (tempState == TEMP_RUN) && (tempCnt == 32'(TEMP_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // per-frame unlock flags, any value written counts
  // an unlock in the start cycle belongs to the new frame, so set wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regUnlocked  <= 1'b0;
      ctrlUnlocked <= 1'b0;
    end else begin
      // unlock register write, only under controller guard rules
      if (netWrStrobe && isRegUnlockAddr && !ctrlBlocks) begin
        regUnlocked <= 1'b1;
      end else if (frameStart) begin
        regUnlocked <= 1'b0;
      end
      if (netWrStrobe && isCtrlUnlockAddr) begin
        ctrlUnlocked <= 1'b1;
      end else if (frameStart) begin
        ctrlUnlocked <= 1'b0;
      end
    end
  end

  // guard bits change only by their own write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regGuard  <= `SWP_RST_GUARD;
      ctrlGuard <= `SWP_RST_GUARD;
    end else begin
      if (wrReg) begin
        regGuard <= netWrData[`SWP_BIT_GUARD];
      end
      if (wrCtrl) begin
        ctrlGuard <= netWrData[`SWP_BIT_GUARD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link layer control byte 0: forwarding rule and temporary use
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      llCtrl0 <= `SWP_RST_LL_CTRL_0;
    end else if (wrLl0) begin
      llCtrl0 <= netWrData[1:0];
    end
  end

  // loop byte with one-second temporary window
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loopByte      <= `SWP_RST_LOOP_BYTE;
      savedLoopByte <= `SWP_RST_LOOP_BYTE;
      tempState     <= TEMP_IDLE;
      tempCnt       <= 32'h0000_0000;
    end else if (wrLl1) begin
      loopByte <= netWrData;
      tempCnt  <= 32'h0000_0000;
      if (llCtrl0[`SWP_BIT_TEMP_USE]) begin
        tempState <= TEMP_RUN;
        if (tempState == TEMP_IDLE) begin
          savedLoopByte <= loopByte;
        end
      end else begin
        tempState <= TEMP_IDLE;
      end
    end else begin
      case (tempState)
        TEMP_IDLE: tempCnt <= 32'h0000_0000;
        TEMP_RUN: begin
          tempCnt <= tempCnt + 32'h0000_0001;
          if (tempDone) begin
            loopByte  <= savedLoopByte;
            tempState <= TEMP_IDLE;
          end
        end
        default: tempState <= TEMP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // accepted writes to non-local addresses pass on, refused ones only flagged
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      extWrEn   <= 1'b0;
      extWrAddr <= 16'h0000;
      extWrData <= 8'h00;
      wrRefused <= 1'b0;
    end else begin
      extWrEn   <= wrOk && !isLocal;
      extWrAddr <= netWrAddr;
      extWrData <= netWrData;
      wrRefused <= netWrStrobe && !wrOk;
    end
  end

  // register reads on both sides
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      netRdData <= 8'h00;
      lpiRdData <= 8'h00;
    end else begin
      netRdData <= readByte(netRdAddr, regGuard, ctrlGuard, llCtrl0, loopByte);
      lpiRdData <= readByte(lpiRdAddr, regGuard, ctrlGuard, llCtrl0, loopByte);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame decision at frame start
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      frameProcess        <= 1'b0;
      frameForward        <= 1'b0;
      frameDrop           <= 1'b0;
      frameSrcAddrByteOut <= 8'h00;
    end else if (frameStart) begin
      // own protocol processed, others per bit
      frameProcess <= frameIsFieldbus;
      frameForward <= frameIsFieldbus || !llCtrl0[`SWP_BIT_FWD_DROP];
      frameDrop    <= !frameIsFieldbus && llCtrl0[`SWP_BIT_FWD_DROP];
      frameSrcAddrByteOut <= frameSrcAddrByteIn | (8'h01 << `SWP_BIT_SRC_LOCAL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // four loop fields drive four port instances
  for (genvar p = 0; p < 4; p++) begin : g_port
    swp_loop_if lpIf ();
    assign lpIf.mode    = swp_loop_e'(loopByte[2*p +: 2]);
    assign lpIf.linkUp  = linkUp[p];
    assign lpIf.busy    = portBusy[p];
    assign lpIf.validRx = portValidRx[p];
    assign lpIf.rewrite = rewritePulse[p];
    assign closedNow[p] = lpIf.closed;
    assign rewritePulse[p] = wrLl1 && (netWrData[2*p +: 2] == 2'b01);
    swp_loop_port u_port (
      .clock   (clock),
      .sys_rst (sys_rst),
      .lp      (lpIf.port)
    );
  end

  // loop state out
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loopClosed <= 4'h0;
    end else begin
      loopClosed <= closedNow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_CTRL_BLOCK: assert property (netWrStrobe && !frameStart && ctrlGuard && !ctrlUnlocked
                                   && !isCtrlUnlockAddr |=> wrRefused && !extWrEn)
    else $error("write passed under controller guard");
  AST_REG_BLOCK: assert property (netWrStrobe && regGuard && !regUnlocked && !isCtrlUnlockAddr
                                  && netWrAddr != `SWP_OFS_REG_UNLOCK
                                  && inRegGuardRange(netWrAddr) |=> wrRefused)
    else $error("write passed under register guard");
  AST_UNLOCK_FREE: assert property (netWrStrobe && isCtrlUnlockAddr |=> !wrRefused)
    else $error("controller unlock write refused");
  AST_UNLOCK_OPENS: assert property (netWrStrobe && isCtrlUnlockAddr ##1 !frameStart ##1
                                     netWrStrobe && !frameStart && !regBlocks |=> !wrRefused)
    else $error("write after controller unlock refused");
  AST_FRAME_RELOCK: assert property (frameStart && !netWrStrobe |=> !regUnlocked && !ctrlUnlocked)
    else $error("unlock survived a new frame");
  AST_REG_GUARD_KEEP: assert property (!(netWrStrobe && netWrAddr == `SWP_OFS_REG_GUARD) |=> $stable(regGuard))
    else $error("register guard changed without its write");
  AST_CTRL_GUARD_KEEP: assert property (!(netWrStrobe && netWrAddr == `SWP_OFS_CTRL_GUARD)
                                        |=> $stable(ctrlGuard))
    else $error("controller guard changed without its write");
  AST_FWD_DROP: assert property (frameStart && !frameIsFieldbus && llCtrl0[0] |=> frameDrop && !frameForward)
    else $error("foreign frame not destroyed");
  AST_FWD_PASS: assert property (frameStart && frameIsFieldbus |=> frameProcess && frameForward)
    else $error("own-protocol frame not processed");
  AST_SRC_MARK: assert property (frameStart |=> frameSrcAddrByteOut[1])
    else $error("source address not marked local");
  AST_TEMP_REVERT: assert property (tempDone && !wrLl1 |=> loopByte == $past(savedLoopByte)
                                    && tempState == TEMP_IDLE)
    else $error("temporary loop settings not restored");
  AST_LOOP_OUT: assert property (1'b1 |=> loopClosed == $past(closedNow))
    else $error("loop state output lags");
endmodule

// File: test/swp_net_master.sv
// fieldbus master model driving frame delimiters and network byte writes
`timescale 1ns/10ps
module swp_net_master (
  // clock
  input  wire logic          clock,
  // frame delimiters and classification
  output logic               frameStart,
  output logic               frameEnd,
  output logic               frameIsFieldbus,
  output swp_pkg::swp_byte_t frameSrcAddrByteIn,
  // network byte writes
  output logic               netWrStrobe,
  output swp_pkg::swp_addr_t netWrAddr,
  output swp_pkg::swp_byte_t netWrData
);
  import swp_pkg::*;

  // idle levels at time zero
  initial begin
    frameStart = 1'b0;
    frameEnd = 1'b0;
    frameIsFieldbus = 1'b0;
    frameSrcAddrByteIn = 8'h00;
    netWrStrobe = 1'b0;
    netWrAddr = 16'h0000;
    netWrData = 8'h00;
  end

  // close the old frame, then open a new one
  task automatic frame(input logic fb, input swp_byte_t src);
    @(posedge clock);
    frameEnd <= 1'b1;
    @(posedge clock);
    frameEnd <= 1'b0;
    frameStart <= 1'b1;
    frameIsFieldbus <= fb;
    frameSrcAddrByteIn <= src;
    @(posedge clock);
    frameStart <= 1'b0;
    // only sampled with the start pulse, so stale values are inverted
    frameIsFieldbus <= ~fb;
    frameSrcAddrByteIn <= ~src;
  endtask

  task automatic wr(input swp_addr_t a, input swp_byte_t d);
    @(posedge clock);
    netWrStrobe <= 1'b1;
    netWrAddr <= a;
    netWrData <= d;
    @(posedge clock);
    netWrStrobe <= 1'b0;
    netWrAddr <= ~a;
    netWrData <= ~d;
  endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the write-guard and loop register bank
`timescale 1ns/10ps
module testbench;
  import swp_pkg::*;
  // clock, reset and bench-driven inputs
  logic       clock;
  logic       sys_rst;
  swp_addr_t  netRdAddr;
  swp_addr_t  lpiRdAddr;
  logic [3:0] linkUp;
  logic [3:0] portBusy;
  logic [3:0] portValidRx;
  // master-driven inputs
  logic       frameStart;
  logic       frameEnd;
  logic       frameIsFieldbus;
  swp_byte_t  frameSrcAddrByteIn;
  logic       netWrStrobe;
  swp_addr_t  netWrAddr;
  swp_byte_t  netWrData;
  // design outputs
  swp_byte_t  netRdData;
  swp_byte_t  lpiRdData;
  logic       extWrEn;
  swp_addr_t  extWrAddr;
  swp_byte_t  extWrData;
  logic       wrRefused;
  logic       frameProcess;
  logic       frameForward;
  logic       frameDrop;
  swp_byte_t  frameSrcAddrByteOut;
  logic [3:0] loopClosed;
  int         fails;
  int         cmpCount;

  ////////////////////////////////////////////////////////////////
  swp_write_guard #(.TEMP_CYCLES(20)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .frameStart(frameStart), .frameEnd(frameEnd),
    .frameIsFieldbus(frameIsFieldbus), .frameSrcAddrByteIn(frameSrcAddrByteIn),
    .netWrStrobe(netWrStrobe), .netWrAddr(netWrAddr), .netWrData(netWrData),
    .netRdAddr(netRdAddr), .netRdData(netRdData), .lpiRdAddr(lpiRdAddr), .lpiRdData(lpiRdData),
    .extWrEn(extWrEn), .extWrAddr(extWrAddr), .extWrData(extWrData), .wrRefused(wrRefused),
    .frameProcess(frameProcess), .frameForward(frameForward), .frameDrop(frameDrop),
    .frameSrcAddrByteOut(frameSrcAddrByteOut), .linkUp(linkUp), .portBusy(portBusy),
    .portValidRx(portValidRx), .loopClosed(loopClosed)
  );
  swp_net_master u_m (
    .clock(clock), .frameStart(frameStart), .frameEnd(frameEnd), .frameIsFieldbus(frameIsFieldbus),
    .frameSrcAddrByteIn(frameSrcAddrByteIn), .netWrStrobe(netWrStrobe), .netWrAddr(netWrAddr),
    .netWrData(netWrData)
  );

  ////////////////////////////////////////////////////////////////
  // clock generator
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // read one byte on both read ports
  task automatic rd(input swp_addr_t a, input swp_byte_t exp);
    @(posedge clock);
    netRdAddr <= a;
    lpiRdAddr <= a;
    @(posedge clock);
    #1;
    chk(16'(netRdData), 16'(exp), "net read");
    chk(16'(lpiRdData), 16'(exp), "local read");
  endtask

  // network write with expected refusal and pass-through
  task automatic wrChk(input swp_addr_t a, input swp_byte_t d, input logic ref_, input logic ext);
    u_m.wr(a, d);
    #1;
    chk(16'({wrRefused, extWrEn}), 16'({ref_, ext}), "write answer");
    if (ext) begin
      chk(extWrAddr, a, "ext addr");
      chk(16'(extWrData), 16'(d), "ext data");
    end
  endtask

  // frame decision and source mark
  task automatic frameChk(input logic fb, input swp_byte_t src, input logic [2:0] exp);
    u_m.frame(fb, src);
    #1;
    chk(16'({frameProcess, frameForward, frameDrop}), 16'(exp), "frame decision");
    chk(16'(frameSrcAddrByteOut), 16'(src | 8'h02), "source mark");
  endtask

  // loop state after four clock edges
  task automatic loopChk(input logic [3:0] exp);
    repeat (4) @(posedge clock);
    #1;
    chk(16'(loopClosed), 16'(exp), "loop state");
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    endSim();
  end

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    fails = 0;
    cmpCount = 0;
    sys_rst = 1'b1;
    netRdAddr = 16'h0000;
    lpiRdAddr = 16'h0000;
    linkUp = 4'h0;
    portBusy = 4'h0;
    portValidRx = 4'h0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(16'h0021, 8'h00);
    rd(16'h0031, 8'h00);
    rd(16'h0100, 8'h00);
    rd(16'h0101, 8'h00);
    // register guard ranges, unlock and persistence
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h0021, 8'h01, 0, 0);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h0000, 8'h11, 1, 0);
    wrChk(16'h0137, 8'h12, 1, 0);
    wrChk(16'h0138, 8'h13, 0, 1);
    wrChk(16'h013A, 8'h14, 1, 0);
    wrChk(16'h0F0F, 8'h15, 1, 0);
    wrChk(16'h0F10, 8'h16, 0, 1);
    wrChk(16'h0021, 8'h00, 1, 0);
    rd(16'h0021, 8'h01);
    wrChk(16'h0030, 8'h00, 0, 1);
    wrChk(16'h0020, 8'h5A, 0, 1);
    wrChk(16'h0010, 8'h17, 0, 1);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h0010, 8'h18, 1, 0);
    wrChk(16'h0020, 8'h00, 0, 1);
    wrChk(16'h0021, 8'h00, 0, 0);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h0010, 8'h19, 0, 1);
    // controller guard
    wrChk(16'h0031, 8'h01, 0, 0);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h1000, 8'h21, 1, 0);
    wrChk(16'h0021, 8'h01, 1, 0);
    wrChk(16'h0030, 8'h77, 0, 1);
    wrChk(16'h1000, 8'h22, 0, 1);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h1000, 8'h23, 1, 0);
    wrChk(16'h0030, 8'h00, 0, 1);
    wrChk(16'h0031, 8'h00, 0, 0);
    rd(16'h0031, 8'h00);
    u_m.frame(1'b1, 8'h50);
    wrChk(16'h1000, 8'h24, 0, 1);
    // forwarding rule and source mark
    wrChk(16'h0100, 8'h01, 0, 0);
    frameChk(1'b0, 8'h50, 3'b001);
    frameChk(1'b1, 8'hA0, 3'b110);
    wrChk(16'h0100, 8'h00, 0, 0);
    frameChk(1'b0, 8'h53, 3'b010);
    // loop modes against link state
    loopChk(4'hF);
    @(posedge clock);
    linkUp <= 4'hF;
    loopChk(4'h0);
    @(posedge clock);
    linkUp <= 4'h0;
    loopChk(4'hF);
    wrChk(16'h0101, 8'h4E, 0, 0);
    loopChk(4'b1110);
    @(posedge clock);
    linkUp <= 4'hF;
    loopChk(4'b1010);
    @(posedge clock);
    portValidRx <= 4'h8;
    @(posedge clock);
    portValidRx <= 4'h0;
    loopChk(4'b0010);
    // port 3 loses link, stays closed, reopens on rewrite of 01
    @(posedge clock);
    linkUp <= 4'h7;
    loopChk(4'b1010);
    @(posedge clock);
    linkUp <= 4'hF;
    loopChk(4'b1010);
    wrChk(16'h0101, 8'h4E, 0, 0);
    loopChk(4'b0010);
    // change held off while port 0 is busy
    @(posedge clock);
    portBusy <= 4'h1;
    wrChk(16'h0101, 8'h4F, 0, 0);
    loopChk(4'b0010);
    @(posedge clock);
    portBusy <= 4'h0;
    loopChk(4'b0011);
    // temporary settings revert, permanent ones stay
    wrChk(16'h0100, 8'h02, 0, 0);
    wrChk(16'h0101, 8'hFF, 0, 0);
    loopChk(4'hF);
    repeat (12) @(posedge clock);
    loopChk(4'hF);
    repeat (10) @(posedge clock);
    loopChk(4'b0011);
    wrChk(16'h0100, 8'h00, 0, 0);
    wrChk(16'h0101, 8'hAA, 0, 0);
    repeat (26) @(posedge clock);
    loopChk(4'h0);
    rd(16'h0101, 8'hAA);
    endSim();
  end
endmodule
